// ==== src/fmc_top.sv ====
// fifo misc control register block with wishbone slave, error capture and dv threshold gate
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
module fmc_top
    import fmc_pkg::*;
#(
    parameter int LVL_W = 12
)(
    input  wire logic             REF_CLK,
    input  wire logic             RSTN,
    input  wire logic             CYC_I,
    input  wire logic             STB_I,
    input  wire logic             WE_I,
    input  wire logic [7:0]       ADR_I,
    input  wire logic [3:0]       SEL_I,
    input  wire logic [31:0]      DAT_I,
    output logic      [31:0]      DAT_O,
    output logic                  ACK_O,
    output logic                  IRQ,
    input  wire logic [2:0]       FMT_DATA,
    output logic      [2:0]       FMT_O,
    output logic      [2:0]       FMT_OE_N,
    input  wire logic             ASY_RX_POP,
    input  wire logic             ASY_RX_EMPTY,
    input  wire logic             ASY_RX_PAUSED,
    input  wire logic             ASY_TX_PUSH,
    input  wire logic             ASY_TX_FULL,
    input  wire logic             ISO_RX_POP,
    input  wire logic             ISO_RX_EMPTY,
    input  wire logic             ISO_RX_PAUSED,
    input  wire logic             ISO_TX_PUSH,
    input  wire logic             ISO_TX_FULL,
    input  wire logic             DV_RX_POP,
    input  wire logic             DV_RX_EMPTY,
    input  wire logic             DV_RX_PAUSED,
    input  wire logic             DV_TS_RELEASED,
    input  wire logic             DV_TX_PUSH,
    input  wire logic             DV_TX_FULL,
    input  wire logic             APP_TX_PUSH,
    output logic                  DV_RX_POP_GO,
    output logic                  DV_TX_PUSH_GO,
    output logic                  APP_TX_PUSH_GO,
    output logic                  DV_RX_TO_APP,
    input  wire logic [LVL_W-1:0] DV_TX_LEVEL,
    input  wire logic             DV_PKT_SENT,
    output logic                  DV_TX_PERMIT,
    output logic                  DV_MODE,
    output logic      [8:0]       ALT_TX_CELL_SIZE,
    output logic      [8:0]       ALT_RX_CELL_SIZE
);

    // level must hold 480+384 bytes; refused at elaboration, not at run time
    if (LVL_W < 10 || LVL_W > 16) begin : g_lvl_check
        $error("fmc_top: LVL_W must be 10 to 16");
    end

    // ****************************************************************
    // register state
    // ****************************************************************
    logic [31:0]          misc_r;
    logic [31:0]          misc_nxt;
    logic [3:0]           ctrl_r;
    logic [3:0]           ctrl_nxt;
    logic [1:0]           isr_r;
    logic [1:0]           isr_nxt;
    logic [1:0]           imr_r;
    logic [1:0]           imr_nxt;
    logic                 ack_r;
    logic                 ack_nxt;
    logic [31:0]          dat_r;
    logic [31:0]          dat_nxt;
    logic [2:0]           fmt_r;
    logic                 first_done_r;
    logic                 first_done_nxt;
    logic                 permit_d_r;
    logic                 srst;
    logic                 wr;
    logic [31:0]          wmask;
    logic [FMC_ERR_W-1:0] err_code;
    logic [FMC_NUM_ERR-1:0] viol;
    logic                 dv_mode;
    logic                 rx_dest;
    logic                 tx_src;
    logic [LVL_W-1:0]     thresh;
    logic                 level_ok;

    // soft reset bit clears misc, control, interrupt and error code registers; bus, format, permit delay and first packet flag wait for RSTN
    assign srst    = !RSTN || ctrl_r[FMC_C_SOFT];
    assign dv_mode = ctrl_r[FMC_C_DV_MODE];
    assign rx_dest = ctrl_r[FMC_C_RX_DEST];
    assign tx_src  = ctrl_r[FMC_C_TX_SRC];

    // ****************************************************************
    // wishbone slave: ack one cycle after the request, write at the ack edge
    // ****************************************************************
    assign wr = CYC_I && STB_I && WE_I && ack_r;

    // byte lane mask from sel
    always_comb begin
        wmask = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            if (SEL_I[b]) begin
                wmask[b*8 +: 8] = 8'hFF;
            end
        end
    end

    // read mux registered at request, unmapped offsets read zero
    always_comb begin
        ack_nxt = CYC_I && STB_I && !ack_r;
        dat_nxt = dat_r;
        if (ack_nxt && !WE_I) begin
            case (ADR_I)
                FMC_ADDR_MISC: begin
                    dat_nxt = misc_r & FMC_MISC_WMASK;
                    dat_nxt[FMC_ERR_HI:FMC_ERR_LO] = err_code; // [R2]
                end
                FMC_ADDR_CTRL: dat_nxt = {29'h0, ctrl_r[2:0]};
                FMC_ADDR_ISR:  dat_nxt = {30'h0, isr_r};
                FMC_ADDR_IMR:  dat_nxt = {30'h0, imr_r};
                default:       dat_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign ACK_O = ack_r;
    assign DAT_O = dat_r;

    // ****************************************************************
    // fifo_misc_control and control register
    // ****************************************************************
    always_comb begin
        misc_nxt = misc_r;
        ctrl_nxt = ctrl_r;
        ctrl_nxt[FMC_C_SOFT] = 1'b0; // self clearing
        if (wr && ADR_I == FMC_ADDR_MISC) begin
            misc_nxt = (misc_r & ~(wmask & FMC_MISC_WMASK)) | (DAT_I & wmask & FMC_MISC_WMASK); // [R7] [R8]
        end
        if (wr && ADR_I == FMC_ADDR_CTRL && SEL_I[0]) begin
            ctrl_nxt = DAT_I[3:0];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (srst) begin
            misc_r <= FMC_MISC_RST; // [R1] [R7] [R8] [R10] [R11]
            ctrl_r <= FMC_CTRL_RST;
        end else begin
            misc_r <= misc_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    assign ALT_TX_CELL_SIZE = misc_r[FMC_TXSZ_HI:FMC_TXSZ_LO];
    assign ALT_RX_CELL_SIZE = misc_r[FMC_RXSZ_HI:FMC_RXSZ_LO];
    assign DV_MODE          = dv_mode;
    assign DV_RX_TO_APP     = rx_dest; // [R13]

    // ****************************************************************
    // format lines: data registered, enable low while driven
    // ****************************************************************
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            fmt_r <= 3'h0;
        end else begin
            fmt_r <= FMT_DATA;
        end
    end

    assign FMT_O    = fmt_r;
    assign FMT_OE_N = {3{misc_r[FMC_FMT_DIS]}}; // [R1]

    // ****************************************************************
    // illegal access detection; dv paths gated by owner selects
    // ****************************************************************
    always_comb begin
        viol     = '0;
        viol[0]  = ASY_RX_POP && ASY_RX_EMPTY;                   // [R3]
        viol[1]  = ASY_RX_POP && !ASY_RX_EMPTY && ASY_RX_PAUSED; // [R3]
        viol[2]  = ASY_TX_PUSH && ASY_TX_FULL;                   // [R3]
        viol[3]  = ISO_RX_POP && ISO_RX_EMPTY;                   // [R4]
        viol[4]  = ISO_RX_POP && !ISO_RX_EMPTY && ISO_RX_PAUSED; // [R4]
        viol[5]  = ISO_TX_PUSH && ISO_TX_FULL;                   // [R4]
        viol[6]  = DV_RX_POP && !rx_dest && DV_RX_EMPTY;         // [R5]
        viol[7]  = DV_RX_POP && !rx_dest && !DV_RX_EMPTY && DV_RX_PAUSED; // [R5]
        viol[8]  = DV_RX_POP && !rx_dest && !DV_RX_EMPTY && !DV_RX_PAUSED && !DV_TS_RELEASED; // [R6]
        viol[9]  = DV_RX_POP && rx_dest;                         // [R6]
        viol[10] = DV_TX_PUSH && !tx_src && DV_TX_FULL;          // [R5]
        viol[11] = DV_TX_PUSH && tx_src;                         // [R6]
    end

    // only legal host accesses reach the dv fifo
    assign DV_RX_POP_GO   = DV_RX_POP && !rx_dest && !DV_RX_EMPTY && !DV_RX_PAUSED && DV_TS_RELEASED; // [R13]
    assign DV_TX_PUSH_GO  = DV_TX_PUSH && !tx_src && !DV_TX_FULL; // [R14]
    assign APP_TX_PUSH_GO = APP_TX_PUSH && tx_src && !DV_TX_FULL; // [R14]

    fmc_err_capture u_err (
        .clk  (REF_CLK),
        .srst (srst),
        .req  (viol),
        .code (err_code)
    );

    // ****************************************************************
    // dv transmit threshold gate
    // ****************************************************************
    assign thresh   = LVL_W'(FMC_BASE_BYTES) +
                      LVL_W'(FMC_ADD_STEP) * LVL_W'(misc_r[FMC_ADD_HI:FMC_ADD_LO]); // [R11]
    assign level_ok = DV_TX_LEVEL >= thresh;

    // first packet flag survives soft reset: only power-on rearms it
    always_comb begin
        first_done_nxt = first_done_r || (dv_mode && DV_PKT_SENT);
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            first_done_r <= 1'b0;
            permit_d_r   <= 1'b0;
        end else begin
            first_done_r <= first_done_nxt;
            permit_d_r   <= DV_TX_PERMIT;
        end
    end

    // select set gates every packet, clear only the first
    always_comb begin
        if (!dv_mode) begin
            DV_TX_PERMIT = 1'b1; // [R12]
        end else if (misc_r[FMC_TSEL]) begin
            DV_TX_PERMIT = level_ok; // [R10]
        end else begin
            DV_TX_PERMIT = first_done_r || level_ok; // [R9]
        end
    end

    // ****************************************************************
    // interrupt status (write one to clear, set wins) and mask
    // ****************************************************************
    always_comb begin
        isr_nxt = isr_r;
        imr_nxt = imr_r;
        if (wr && ADR_I == FMC_ADDR_ISR && SEL_I[0]) begin
            isr_nxt = isr_r & ~DAT_I[1:0];
        end
        if (wr && ADR_I == FMC_ADDR_IMR && SEL_I[0]) begin
            imr_nxt = DAT_I[1:0];
        end
        if (|viol) begin
            isr_nxt[FMC_I_ERR] = 1'b1;
        end
        if (dv_mode && DV_TX_PERMIT && !permit_d_r) begin
            isr_nxt[FMC_I_TXGO] = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (srst) begin
            isr_r <= FMC_IRQ_RST;
            imr_r <= FMC_IRQ_RST;
        end else begin
            isr_r <= isr_nxt;
            imr_r <= imr_nxt;
        end
    end

    assign IRQ = |(isr_r & imr_r);

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_fmt_float: assert property (@(posedge REF_CLK) disable iff (srst) // [R1]
        (wr && ADR_I == FMC_ADDR_MISC && SEL_I[3] && DAT_I[FMC_FMT_DIS]) |=> (FMT_OE_N == 3'h7))
        else $error("format lines not floated after disable write");

    a_err_reset: assert property (@(posedge REF_CLK) // [R2]
        !RSTN |=> (err_code == FMC_ERR_NONE))
        else $error("error code not zero after reset");

    a_asy_empty: assert property (@(posedge REF_CLK) disable iff (srst) // [R3]
        (viol == 12'h001) |=> (err_code == 4'h1))
        else $error("async empty pop code wrong");

    a_iso_empty: assert property (@(posedge REF_CLK) disable iff (srst) // [R4]
        (viol == 12'h008) |=> (err_code == 4'h4))
        else $error("iso empty pop code wrong");

    a_dv_full: assert property (@(posedge REF_CLK) disable iff (srst) // [R5]
        (DV_TX_PUSH && !tx_src && DV_TX_FULL && viol[9:0] == 10'h000) |=> (err_code == 4'hB))
        else $error("dv full push code wrong");

    a_app_pop: assert property (@(posedge REF_CLK) disable iff (srst) // [R6]
        (DV_RX_POP && rx_dest && !viol[10] && !viol[11]) |=> (err_code == 4'hA))
        else $error("application mode pop code wrong");

    a_txsz_write: assert property (@(posedge REF_CLK) disable iff (srst) // [R7]
        (wr && ADR_I == FMC_ADDR_MISC && SEL_I[2]) |=> (ALT_TX_CELL_SIZE[7:0] == $past(DAT_I[23:16])))
        else $error("alternate tx cell size not written");

    a_rxsz_write: assert property (@(posedge REF_CLK) disable iff (srst) // [R8]
        (wr && ADR_I == FMC_ADDR_MISC && SEL_I[0]) |=> (ALT_RX_CELL_SIZE[7:0] == $past(DAT_I[7:0])))
        else $error("alternate rx cell size not written");

    a_thresh_each: assert property (@(posedge REF_CLK) disable iff (srst) // [R10] [R11]
        (dv_mode && misc_r[FMC_TSEL] && DV_TX_LEVEL < LVL_W'(480) + LVL_W'({misc_r[13:12], 7'h00}))
            |-> !DV_TX_PERMIT)
        else $error("dv packet permitted below threshold");

    a_first_held: assert property (@(posedge REF_CLK) disable iff (srst) // [R9]
        (dv_mode && !first_done_r && !level_ok) |-> !DV_TX_PERMIT)
        else $error("first dv packet permitted early");

    a_non_dv: assert property (@(posedge REF_CLK) disable iff (srst) // [R12]
        !dv_mode |-> DV_TX_PERMIT)
        else $error("threshold acted outside dv mode");

    a_rx_ignore: assert property (@(posedge REF_CLK) disable iff (srst) // [R13]
        rx_dest |-> !DV_RX_POP_GO)
        else $error("host pop passed in application mode");

    a_tx_ignore: assert property (@(posedge REF_CLK) disable iff (srst) // [R14]
        tx_src |-> (!DV_TX_PUSH_GO && (APP_TX_PUSH_GO == (APP_TX_PUSH && !DV_TX_FULL))))
        else $error("dv tx owner gating wrong");

    a_err_hold: assert property (@(posedge REF_CLK) disable iff (srst) // [R15]
        (viol == 12'h000) |=> $stable(err_code))
        else $error("error code changed without event");

endmodule

// ==== src/fmc_pkg.sv ====
// package of register map, field positions and constants for the fifo misc control block
//
// Overview of operation
// [R1] format_driver_disable set floats the three application format lines; clear drives them.
// [R2] processor_error_code is read-only, four bits, zero after any reset.
// [R3] codes 1h/2h/3h: async rx pop empty, async rx pop paused, async tx push full.
// [R4] codes 4h/5h/6h: iso rx pop empty, iso rx pop paused, iso tx push full.
// [R5] codes 7h/8h/Bh: dv rx pop empty, dv rx pop paused, dv tx push full.
// [R6] codes 9h/Ah/Ch: dv pop before timestamp release, pop or push in application mode.
// [R7] alt_tx_cell_size is a nine-bit read-write field, zero after reset.
// [R8] alt_rx_cell_size is a nine-bit read-write field, zero after reset.
// [R9] threshold select clear: only first dv packet after reset waits for 480+N bytes.
// [R10] threshold select set: every dv packet waits for 480+N bytes; default clear.
// [R11] threshold addition field gives N of 0, 128, 256 or 384 bytes.
// [R12] threshold settings act only in dv mode.
// [R13] rx destination select set: dv packets go to application, processor pops ignored.
// [R14] tx source select set: only application writes the dv tx fifo, processor ignored.
// [R15] each illegal push or pop loads the error code, held until next event or reset.
package fmc_pkg;

    // ****************************************************************
    // register byte addresses
    // ****************************************************************
    localparam logic [7:0]  FMC_ADDR_MISC = 8'hF8;
    localparam logic [7:0]  FMC_ADDR_CTRL = 8'h40;
    localparam logic [7:0]  FMC_ADDR_ISR  = 8'h44;
    localparam logic [7:0]  FMC_ADDR_IMR  = 8'h48;

    // ****************************************************************
    // fifo_misc_control fields; field bit 00 is the word msb
    // ****************************************************************
    localparam int          FMC_FMT_DIS   = 31;
    localparam int          FMC_ERR_HI    = 30;
    localparam int          FMC_ERR_LO    = 27;
    localparam int          FMC_TXSZ_HI   = 24;
    localparam int          FMC_TXSZ_LO   = 16;
    localparam int          FMC_TSEL      = 15;
    localparam int          FMC_ADD_HI    = 13;
    localparam int          FMC_ADD_LO    = 12;
    localparam int          FMC_RXSZ_HI   = 8;
    localparam int          FMC_RXSZ_LO   = 0;
    localparam logic [31:0] FMC_MISC_WMASK = 32'h81FF_B1FF;
    localparam logic [31:0] FMC_MISC_RST   = 32'h0000_0000;

    // ****************************************************************
    // control, status and mask bits
    // ****************************************************************
    localparam int          FMC_C_DV_MODE = 0;
    localparam int          FMC_C_RX_DEST = 1;
    localparam int          FMC_C_TX_SRC  = 2;
    localparam int          FMC_C_SOFT    = 3;
    localparam logic [3:0]  FMC_CTRL_RST  = 4'h0;
    localparam int          FMC_I_ERR     = 0;
    localparam int          FMC_I_TXGO    = 1;
    localparam logic [1:0]  FMC_IRQ_RST   = 2'h0;

    // ****************************************************************
    // error codes; encoder request bit k reports code k+1
    // ****************************************************************
    localparam int          FMC_ERR_W     = 4;
    localparam int          FMC_NUM_ERR   = 12;
    localparam logic [3:0]  FMC_ERR_NONE  = 4'h0;

    // ****************************************************************
    // dv transmit threshold
    // ****************************************************************
    localparam int          FMC_BASE_BYTES = 480;
    localparam int          FMC_ADD_STEP   = 128;

endpackage

// ==== src/fmc_err_capture.sv ====
// error code capture register: newest illegal access code, held until next one
`timescale 1ns/1ps
module fmc_err_capture
    import fmc_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire logic [FMC_NUM_ERR-1:0] req,
    output logic      [FMC_ERR_W-1:0]   code
);

    logic [FMC_ERR_W-1:0] code_r;
    logic [FMC_ERR_W-1:0] code_nxt;

    // ****************************************************************
    // encoder: highest code wins when two events share a cycle
    // ****************************************************************
    always_comb begin
        code_nxt = code_r;
        for (int k = 0; k < FMC_NUM_ERR; k++) begin
            if (req[k]) begin
                code_nxt = FMC_ERR_W'(k + 1); // [R15]
            end
        end
    end

    // register, cleared by either reset
    always_ff @(posedge clk) begin
        if (srst) begin
            code_r <= FMC_ERR_NONE; // [R2]
        end else begin
            code_r <= code_nxt;
        end
    end

    assign code = code_r;

endmodule

// ==== dv/fmc_far_model.sv ====
// far-side model: host processor fifo attempts and the fifo status seen with them
`timescale 1ns/1ps
module fmc_far_model (
    input  wire logic [3:0]  ev,
    output logic      [16:0] att
);
    // ********
    // attempt decode
    // ********
    // ev picks one attempt; idle empty, paused and full flags stay low, timestamp released stays high
    always_comb begin
        att     = 17'h00000;
        att[16] = (ev != 4'h9);              // timestamp released except for the early-pop case
        case (ev)
            4'h1: att[1:0]   = 2'h3;         // async pop while empty
            4'h2: att[2:0]   = 3'h5;         // async pop while paused, not empty
            4'h3: att[4:3]   = 2'h3;         // async push while full
            4'h4: att[6:5]   = 2'h3;
            4'h5: att[7:5]   = 3'h5;
            4'h6: att[9:8]   = 2'h3;
            4'h7: att[11:10] = 2'h3;
            4'h8: att[12:10] = 3'h5;
            4'h9, 4'hA, 4'hD: att[10] = 1'b1; // bare dv pop; legality set by ctrl and release
            4'hB: att[14:13] = 2'h3;
            4'hC, 4'hE: att[13] = 1'b1;      // bare dv push
            4'hF: att[15]    = 1'b1;         // application write
            default: att[16] = 1'b1;
        endcase
    end
endmodule

// ==== dv/fifo_misc_control_test.sv ====
// self-checking bench for the fifo misc control register block
`timescale 1ns/1ps
module fifo_misc_control_test;
    import fmc_pkg::*;
    logic        REF_CLK, RSTN, CYC_I, STB_I, WE_I, DV_PKT_SENT;
    logic [7:0]  ADR_I;
    logic [3:0]  SEL_I, ev;
    logic [31:0] DAT_I, DAT_O, d;
    logic [31:0] exp_q[$];
    logic [2:0]  FMT_DATA, FMT_O, FMT_OE_N;
    logic [11:0] DV_TX_LEVEL;
    logic [8:0]  ALT_TX_CELL_SIZE, ALT_RX_CELL_SIZE;
    logic        ACK_O, IRQ, DV_RX_POP_GO, DV_TX_PUSH_GO, APP_TX_PUSH_GO, DV_RX_TO_APP, DV_TX_PERMIT, DV_MODE;
    wire  [16:0] att;
    int          error_cnt, n_tests, seed, k;

    fmc_far_model i_far (.ev(ev), .att(att));

    fmc_top #(.LVL_W(12)) i_dut (
        .REF_CLK(REF_CLK), .RSTN(RSTN), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
        .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .IRQ(IRQ), .FMT_DATA(FMT_DATA),
        .FMT_O(FMT_O), .FMT_OE_N(FMT_OE_N), .ASY_RX_POP(att[0]), .ASY_RX_EMPTY(att[1]),
        .ASY_RX_PAUSED(att[2]), .ASY_TX_PUSH(att[3]), .ASY_TX_FULL(att[4]), .ISO_RX_POP(att[5]),
        .ISO_RX_EMPTY(att[6]), .ISO_RX_PAUSED(att[7]), .ISO_TX_PUSH(att[8]), .ISO_TX_FULL(att[9]),
        .DV_RX_POP(att[10]), .DV_RX_EMPTY(att[11]), .DV_RX_PAUSED(att[12]), .DV_TS_RELEASED(att[16]),
        .DV_TX_PUSH(att[13]), .DV_TX_FULL(att[14]), .APP_TX_PUSH(att[15]), .DV_RX_POP_GO(DV_RX_POP_GO),
        .DV_TX_PUSH_GO(DV_TX_PUSH_GO), .APP_TX_PUSH_GO(APP_TX_PUSH_GO), .DV_RX_TO_APP(DV_RX_TO_APP),
        .DV_TX_LEVEL(DV_TX_LEVEL), .DV_PKT_SENT(DV_PKT_SENT), .DV_TX_PERMIT(DV_TX_PERMIT),
        .DV_MODE(DV_MODE), .ALT_TX_CELL_SIZE(ALT_TX_CELL_SIZE), .ALT_RX_CELL_SIZE(ALT_RX_CELL_SIZE)
    );

    // ********
    // helpers
    // ********
    task automatic final_report;
        if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle; a read notes its expected word for the monitor
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] v);
        int i;
        if (!we) exp_q.push_back(v);
        @(posedge REF_CLK);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I  <= we;
        ADR_I <= a;
        DAT_I <= v;
        i = 0;
        do begin
            @(posedge REF_CLK);
            i++;
        end while (ACK_O !== 1'b1 && i < 20);
        if (i >= 20) begin
            error_cnt++;
            final_report();
        end
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        WE_I  <= 1'b0;
    endtask

    // one-cycle attempt; go is the expected {rx pop, tx push, app push} forward
    task automatic fire(input logic [3:0] e, input logic [2:0] go);
        @(posedge REF_CLK);
        ev <= e;
        @(negedge REF_CLK);
        chk({DV_RX_POP_GO, DV_TX_PUSH_GO, APP_TX_PUSH_GO}, go);
        @(posedge REF_CLK);
        ev <= 4'h0;
    endtask

    task automatic lvl(input int n, input logic e);
        @(posedge REF_CLK);
        DV_TX_LEVEL <= n[11:0];
        @(negedge REF_CLK);
        chk(DV_TX_PERMIT, e);
    endtask

    // read data is only valid in the ack cycle, so compare at the edge that samples ack
    always @(posedge REF_CLK) begin
        if (ACK_O === 1'b1 && WE_I === 1'b0) begin
            if (exp_q.size() > 0) chk(DAT_O, exp_q.pop_front());
            else error_cnt++;
        end
    end

    // clock
    initial begin
        REF_CLK = 1'b0;
        forever #50 REF_CLK = ~REF_CLK;
    end

    // ********
    // main sequence
    // ********
    initial begin
        {RSTN, CYC_I, STB_I, WE_I, DV_PKT_SENT} = 5'h00;
        {ADR_I, DAT_I, FMT_DATA, DV_TX_LEVEL, ev} = 59'h0;
        SEL_I = 4'hF;
        error_cnt = 0;
        n_tests = 0;
        seed = 2836;
        repeat (16) @(posedge REF_CLK);
        RSTN <= 1'b1;
        wb(1'b0, FMC_ADDR_MISC, FMC_MISC_RST);
        chk(FMT_OE_N, 3'h0);
        wb(1'b0, 8'h00, 32'h0);
        wb(1'b1, FMC_ADDR_MISC, 32'hFFFFFFFF);
        wb(1'b0, FMC_ADDR_MISC, FMC_MISC_WMASK);
        chk(FMT_OE_N, 3'h7);
        // random field values; the format lines follow the disable bit
        repeat (4) begin
            d = $random(seed);
            wb(1'b1, FMC_ADDR_MISC, d);
            FMT_DATA <= d[2:0];
            wb(1'b0, FMC_ADDR_MISC, d & FMC_MISC_WMASK);
            @(negedge REF_CLK);
            chk({ALT_TX_CELL_SIZE, ALT_RX_CELL_SIZE}, {d[24:16], d[8:0]});
            chk({FMT_OE_N, FMT_O}, {{3{d[31]}}, d[2:0]});
        end
        // every error code in turn, each replacing the last
        wb(1'b1, FMC_ADDR_MISC, 32'h0);
        wb(1'b1, FMC_ADDR_IMR, 32'h1);
        for (k = 1; k <= 12; k++) begin
            wb(1'b1, FMC_ADDR_CTRL, {29'h0, k == 12, k == 10, 1'b1});
            fire(k[3:0], 3'h0);
            wb(1'b0, FMC_ADDR_MISC, {1'b0, k[3:0], 27'h0});
            chk(IRQ, 1'b1);
        end
        wb(1'b1, FMC_ADDR_ISR, 32'h1);
        @(negedge REF_CLK);
        chk(IRQ, 1'b0);
        wb(1'b1, FMC_ADDR_IMR, 32'h0);
        fire(4'h1, 3'h0);
        wb(1'b0, FMC_ADDR_MISC, {1'b0, 4'h1, 27'h0});
        chk(IRQ, 1'b0);
        wb(1'b1, FMC_ADDR_IMR, 32'h1);
        @(negedge REF_CLK);
        chk(IRQ, 1'b1);
        // fifo ownership by the application port
        wb(1'b1, FMC_ADDR_CTRL, 32'h7);
        fire(4'hD, 3'h0);
        chk(DV_RX_TO_APP, 1'b1);
        fire(4'hE, 3'h0);
        fire(4'hF, 3'h1);
        wb(1'b1, FMC_ADDR_CTRL, 32'h1);
        fire(4'hD, 3'h4);
        fire(4'hE, 3'h2);
        fire(4'hF, 3'h0);
        // transmit threshold; outside dv mode the gate stays open
        wb(1'b1, FMC_ADDR_CTRL, 32'h0);
        wb(1'b1, FMC_ADDR_MISC, 32'h0000B000);
        lvl(0, 1'b1);
        wb(1'b1, FMC_ADDR_MISC, 32'h0);
        wb(1'b1, FMC_ADDR_CTRL, 32'h1);
        lvl(479, 1'b0);
        chk(DV_MODE, 1'b1);
        lvl(480, 1'b1);
        wb(1'b0, FMC_ADDR_ISR, 32'h3);
        @(posedge REF_CLK);
        DV_PKT_SENT <= 1'b1;
        @(posedge REF_CLK);
        DV_PKT_SENT <= 1'b0;
        lvl(0, 1'b1);
        for (k = 0; k < 4; k++) begin
            wb(1'b1, FMC_ADDR_MISC, 32'h8000 | (k << 12));
            lvl(FMC_BASE_BYTES + FMC_ADD_STEP * k - 1, 1'b0);
            lvl(FMC_BASE_BYTES + FMC_ADD_STEP * k, 1'b1);
        end
        // software reset clears every field again
        wb(1'b1, FMC_ADDR_MISC, 32'hFFFFFFFF);
        wb(1'b1, FMC_ADDR_CTRL, 32'h8);
        wb(1'b0, FMC_ADDR_MISC, 32'h0);
        wb(1'b0, FMC_ADDR_CTRL, 32'h0);
        wb(1'b0, FMC_ADDR_ISR, 32'h0);
        chk(IRQ, 1'b0);
        final_report();
    end
endmodule
